// ==== bench/test_mcu_core_cycle_reset_memmap.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_mcu_core_cycle_reset_memmap
  import mcucc_pkg::*;
;
  logic            clk, rst_n, por, low_voltage_reset, pin_n, wdg;
  logic [3:0]      adr;
  logic            rd, wr, wreq, br, asel, mwa, bop, dwe;
  logic [31:0]     wdat, rdat, q;
  logic [NIRQ-1:0] irq;
  logic [PC_W-1:0] boff, pc, p;
  logic [CFG_W-1:0] cfg;
  logic [7:0]      dadr, dwd;
  logic            cpw, fbl;
  logic            ph1, ph2, irl, xen, ren, psel, filt, blk, crst, aacc, bill, found;
  logic [4:0]      trim;
  logic [8:0]      phys;
  int              num_errors, num_checks, i;
  localparam logic [CFG_W-1:0] C1 = 14'h2115;
  localparam logic [CFG_W-1:0] C2 = 14'h0007;

  mcucc_core DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .por_in(por), .low_voltage_reset_in(low_voltage_reset),
    .external_reset_pin_n_in(pin_n), .watchdog_reset_in(wdg), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .irq_req_in(irq), .branch_in(br), .branch_offset_in(boff),
    .cfg_word_in(cfg), .cfg_prog_we_in(cpw), .flash_blank_in(fbl), .aux_sel_in(asel),
    .move_w_to_aux_in(mwa), .move_aux_to_w_in(1'b0), .bit_op_in(bop), .data_addr_in(dadr),
    .data_wdata_in(dwd), .data_we_in(dwe), .phase_one_out(ph1), .phase_two_out(ph2),
    .pc_out(pc), .ir_latch_out(irl), .crystal_osc_enable_out(xen),
    .internal_osc_enable_out(ren), .cpu_clk_sel_pll_out(psel),
    .pll_internal_filter_out(filt), .rc_freq_trim_out(trim),
    .flash_read_block_out(blk), .core_reset_out(crst), .data_phys_addr_out(phys),
    .aux_access_out(aacc), .bit_op_illegal_out(bill)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  // Avalon access, held until waitrequest is sampled low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      test_done;
    end
  endtask

  task automatic dwr(logic aux, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    asel <= aux;
    mwa <= aux;
    dadr <= a;
    dwd <= d;
    dwe <= 1'b1;
    @(posedge clk);
    asel <= 1'b0;
    mwa <= 1'b0;
    dwe <= 1'b0;
  endtask

  // One programmer write pulse of the option word
  task automatic prog(logic [CFG_W-1:0] v, logic b);
    @(posedge clk);
    cfg <= v;
    fbl <= b;
    cpw <= 1'b1;
    @(posedge clk);
    cpw <= 1'b0;
    fbl <= 1'b0;
  endtask

  task automatic wait_pc(logic [PC_W-1:0] v, int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      if (pc === v)
        break;
    end
    chk("pc", {19'h0, v}, {19'h0, pc});
  endtask

  task automatic rst(int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  initial
  begin
    {por, low_voltage_reset, wdg, rd, wr, br, asel, mwa, bop, dwe, cpw, fbl} = '0;
    pin_n = 1'b1;
    rst_n = 1'b0;
    {adr, wdat, irq, boff, dadr, dwd} = '0;
    cfg = C1;
    num_errors = 0;
    num_checks = 0;
    rst(16);
    chk("pc0", 0, {19'h0, pc});
    bus(0, A_CTRL, 0);
    chk("ctrl", 32'h1, q);
    bus(0, A_IRQEN, 0);
    chk("irqen", 0, q);
    bus(1, A_CFG, 0);
    bus(0, A_CFG, 0);
    chk("cfg", {18'h0, C1}, q);
    bus(0, 4'h2, 0);
    chk("unmap", 0, q);
    chk("opt", 32'h3A82, {blk, filt, trim, 4'h0, crst, xen, ren});
    $display("test registers done");
    prog(C2, 1'b0);
    bus(0, A_CFG, 0);
    chk("cfglock", {18'h0, C1}, q);
    prog(C2, 1'b1);
    bus(0, A_CFG, 0);
    chk("cfgblank", {18'h0, C2}, q);
    chk("blk", 0, {31'h0, blk});
    prog(C1, 1'b0);
    bus(0, A_CFG, 0);
    chk("cfgopen", {18'h0, C1}, q);
    $display("test option word done");
    p = {12'h0, ph1};
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      chk("ph", 1, {31'h0, ph1 ^ ph2});
      chk("ph1", {31'h0, ~p[0]}, {31'h0, ph1});
      chk("irl", {31'h0, ~p[0]}, {31'h0, irl});
      p = {12'h0, ph1};
    end
    $display("test phases done");
    repeat (20) @(posedge clk);
    br <= 1'b1;
    boff <= 13'h1FF0;
    found = 1'b0;
    p = pc;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      if (i == 1)
        br <= 1'b0;
      if (pc !== p && pc === p + 13'h1FF0)
        found = 1'b1;
      p = pc;
    end
    chk("branch", 1, {31'h0, found});
    $display("test branch done");
    dwr(1, R_CLK_ADDR, 8'h18);
    repeat (2) @(posedge clk);
    chk("clk18", 3, {30'h0, xen, ren});
    dwr(0, F_RSR_ADDR, 8'h07);
    dwr(1, R_AUX_INDIRECT_PORT_ADDR, 8'h08);
    repeat (2) @(posedge clk);
    chk("clk08", 1, {30'h0, xen, ren});
    dwr(0, F_BANK_ADDR, 8'h20);
    dadr <= 8'h45;
    bop <= 1'b1;
    repeat (2) @(posedge clk);
    chk("bank1", 32'h345, {22'h0, bill, phys});
    dadr <= 8'h25;
    repeat (2) @(posedge clk);
    chk("bitok", 32'h025, {22'h0, bill, phys});
    bop <= 1'b0;
    dwr(0, F_FSR_ADDR, 8'h50);
    dadr <= F_PRIMARY_INDIRECT_PORT_ADDR;
    repeat (2) @(posedge clk);
    chk("primary_indirect_port", 32'h150, {23'h0, phys});
    $display("test planes done");
    cfg <= C2;
    for (i = 0; i < 4; i++)
    begin
      dwr(1, R_CLK_ADDR, 8'h08);
      dwr(0, F_BANK_ADDR, 8'h20);
      repeat (20) @(posedge clk);
      case (i)
        0: low_voltage_reset <= 1'b1;
        1: pin_n <= 1'b0;
        2: wdg <= 1'b1;
        default: por <= 1'b1;
      endcase
      wait_pc(0, 4);
      chk("crst", 1, {31'h0, crst});
      {por, low_voltage_reset, wdg} <= '0;
      pin_n <= 1'b1;
      dadr <= 8'h45;
      repeat (3) @(posedge clk);
      chk("clkdef", 2, {30'h0, xen, ren});
      chk("bank0", 32'h045, {23'h0, phys});
      chk("filt", {31'h0, i == 3 ? C2[8] : C1[8]}, {31'h0, filt});
    end
    $display("test resets done");
    for (i = 0; i < NIRQ; i++)
    begin
      rst(2);
      bus(1, A_IRQEN, 32'h1 << i);
      repeat (60) @(posedge clk);
      irq <= '1;
      if (i != IRQ_RESERVED_IDX)
        wait_pc(IRQ_BASE + i[12:0], 20);
      else
        repeat (20) @(posedge clk);
      bus(0, A_CTRL, 0);
      chk("insvc", i == IRQ_RESERVED_IDX ? 1 : 3, q);
      irq <= '0;
    end
    rst(2);
    bus(1, A_IRQEN, 32'h1FFFF);
    repeat (60) @(posedge clk);
    irq <= 17'h00208;
    wait_pc(13'h0004, 20);
    $display("test interrupts done");
    test_done;
  end
endmodule // test_mcu_core_cycle_reset_memmap
`default_nettype wire

// ==== core/mcucc_core.sv ====
// Summary of operation
// - CPU clock halves into phase one and phase two per cycle.
// - PC updates in phase one, instruction latched phase two, executes next cycle.
// - Branches take two cycles; target is PC plus signed offset.
// - Crystal PLL clock feeds USB and CPU; RC clock may also feed CPU.
// - Aux register 07 bit 4 enables crystal, bit 3 enables internal oscillator.
// - Power-on, low voltage, external pin and watchdog all reset the core.
// - Power-on reset restores controls; filter choice taken from option word.
// - Watchdog and pin resets restore controls like power-on.
// - Power-up, pin or low-voltage reset restart the PC at zero.
// - USB interrupts vector to 0001h..000Ah in fixed order.
// - Others vector 000Bh..000Fh, 0010h reserved, Timer1 at 0011h.
// - Each source has its own enable; disabled sources never vector.
// - Primary plane: SFRs low, RAM above, direct and indirect access.
// - Primary indirect port has no storage; targets pointer's address.
// - Primary RAM 0x20..0x7F; bit operations only on 0x20..0x3F.
// - 0x40..0x7F banked by bit 5 of primary register 03.
// - Aux plane reached only by the two move instructions with W.
// - Aux pointer at primary 05h; aux address 00h targets pointer address.
// - Aux plane holds two 64-byte RAMs and five 8-byte FIFOs.
// - Program memory 8K x 14 words, 0000h..1FFFh, vectors lowest.
// - 32-word config memory written only by the flash programmer.
// - Option bit 13 set blocks external flash reads.
// - Option word always readable; written only if unprotected or blank.
// - Bit 8 picks PLL filter; bits 4..0 RC trim; others reserved zero.
// - Single nesting level; 17 sources, 16 vectors, source 15 at 0010h never vectors.
`timescale 1ns/1ps
`default_nettype none
module mcucc_core
  import mcucc_pkg::*;
#(
  parameter int NSRC = NIRQ
)(
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  // Reset sources
  input  wire logic                por_in,
  input  wire logic                low_voltage_reset_in,
  input  wire logic                external_reset_pin_n_in,
  input  wire logic                watchdog_reset_in,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Interrupt requests and instruction stream
  input  wire logic [NSRC-1:0]     irq_req_in,
  input  wire logic                branch_in,
  input  wire logic [PC_W-1:0]     branch_offset_in,
  input  wire logic [CFG_W-1:0]    cfg_word_in,
  input  wire logic                cfg_prog_we_in,
  input  wire logic                flash_blank_in,
  // Data plane access
  input  wire logic                aux_sel_in,
  input  wire logic                move_w_to_aux_in,
  input  wire logic                move_aux_to_w_in,
  input  wire logic                bit_op_in,
  input  wire logic [7:0]          data_addr_in,
  input  wire logic [DATA_W-1:0]   data_wdata_in,
  input  wire logic                data_we_in,
  // Outputs
  output logic                     phase_one_out,
  output logic                     phase_two_out,
  output logic [PC_W-1:0]          pc_out,
  output logic                     ir_latch_out,
  output logic                     crystal_osc_enable_out,
  output logic                     internal_osc_enable_out,
  output logic                     cpu_clk_sel_pll_out,
  output logic                     pll_internal_filter_out,
  output logic [4:0]               rc_freq_trim_out,
  output logic                     flash_read_block_out,
  output logic                     core_reset_out,
  output logic [8:0]               data_phys_addr_out,
  output logic                     aux_access_out,
  output logic                     bit_op_illegal_out
);

  logic             any_reset;
  mcucc_phase_t     phase_q, phase_d;
  logic [PC_W-1:0]  pc_q, pc_d, ret_q, ret_d;
  logic             br_q, br_d, in_isr_q, in_isr_d, irlat_q, irlat_d;
  logic             run_q, run_d;
  logic [NSRC-1:0]  irq_en_q, irq_en_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [7:0]       fsr_q, fsr_d, rsr_q, rsr_d, clk_q, clk_d, bank_q, bank_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             wait_q, wait_d;
  logic [8:0]       paddr_q, paddr_d;
  logic             aux_q, aux_d, bitill_q, bitill_d, rst_q;
  logic [NSRC-1:0]  irq_live;
  logic             irq_hit;
  logic [PC_W-1:0]  irq_vec;
  logic [7:0]       aux_addr;

  assign any_reset = !rst_n_in || por_in || low_voltage_reset_in
                     || !external_reset_pin_n_in || watchdog_reset_in;

  // Masked sources, lowest vector wins
  generate
    for (genvar i = 0; i < NSRC; i++)
    begin : g_irq
      assign irq_live[i] = irq_req_in[i] && irq_en_q[i]
                           && (i != IRQ_RESERVED_IDX);
    end
  endgenerate

  always_comb
  begin
    irq_hit = 1'b0;
    irq_vec = RESET_VECTOR;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (irq_live[i])
      begin
        irq_hit = 1'b1;
        irq_vec = IRQ_BASE + PC_W'(i);
      end
    end
  end

  // Instruction sequencer
  always_comb
  begin
    phase_d  = (phase_q == MCUCC_PH_ONE) ? MCUCC_PH_TWO : MCUCC_PH_ONE;
    pc_d     = pc_q;
    ret_d    = ret_q;
    br_d     = br_q;
    in_isr_d = in_isr_q;
    irlat_d  = (phase_q == MCUCC_PH_TWO) && run_q;
    if (run_q && phase_q == MCUCC_PH_ONE)
    begin
      if (br_q)
        br_d = 1'b0;
      else if (irq_hit && !in_isr_q)
      begin
        ret_d    = pc_q;
        pc_d     = irq_vec;
        in_isr_d = 1'b1;
      end
      else if (branch_in)
      begin
        pc_d = pc_q + branch_offset_in;
        br_d = 1'b1;
      end
      else
        pc_d = (pc_q == PC_LAST) ? RESET_VECTOR : pc_q + PC_W'(1);
    end
    if (any_reset)
    begin
      phase_d  = MCUCC_PH_ONE;
      pc_d     = RESET_VECTOR;
      ret_d    = RESET_VECTOR;
      br_d     = 1'b0;
      in_isr_d = 1'b0;
      irlat_d  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    phase_q  <= phase_d;
    pc_q     <= pc_d;
    ret_q    <= ret_d;
    br_q     <= br_d;
    in_isr_q <= in_isr_d;
    irlat_q  <= irlat_d;
  end

  // Registers, option word and data plane decode
  always_comb
  begin
    run_d    = run_q;
    irq_en_d = irq_en_q;
    cfg_d    = cfg_q;
    fsr_d    = fsr_q;
    rsr_d    = rsr_q;
    clk_d    = clk_q;
    bank_d   = bank_q;
    rdata_d  = rdata_q;
    wait_d   = 1'b1;
    paddr_d  = {1'b0, data_addr_in};
    aux_d    = 1'b0;
    bitill_d = 1'b0;
    // Effective aux address, indirect port resolved through the pointer
    aux_addr = (data_addr_in == R_AUX_INDIRECT_PORT_ADDR) ? rsr_q : data_addr_in;
    if (cfg_prog_we_in && (!cfg_q[CFG_PROTECT_BIT] || flash_blank_in))
      cfg_d = cfg_word_in & ~CFG_RESERVED_MASK;
    if ((avs_read_in || avs_write_in) && wait_q)
    begin
      wait_d = 1'b0;
      if (avs_read_in)
      begin
        unique case (avs_address_in)
          A_CTRL:   rdata_d = {30'h0, in_isr_q, run_q};
          A_STATUS: rdata_d = {19'h0, pc_q};
          A_CFG:    rdata_d = {18'h0, cfg_q};
          A_IRQEN:  rdata_d = 32'(irq_en_q);
          default:  rdata_d = 32'h0000_0000;
        endcase
      end
      else if (avs_address_in == A_CTRL)
        run_d = avs_writedata_in[CTRL_RUN_BIT];
      else if (avs_address_in == A_IRQEN)
        irq_en_d = avs_writedata_in[NSRC-1:0];
    end
    if (aux_sel_in && (move_w_to_aux_in || move_aux_to_w_in))
    begin
      aux_d   = 1'b1;
      paddr_d = {1'b1, aux_addr};
      if (data_we_in && move_w_to_aux_in && aux_addr == R_CLK_ADDR)
        clk_d = data_wdata_in;
    end
    else if (!aux_sel_in)
    begin
      if (data_addr_in == F_PRIMARY_INDIRECT_PORT_ADDR)
        paddr_d = {1'b0, fsr_q};
      if (paddr_d[7:0] >= F_BANKED_LO && paddr_d[7:0] <= F_RAM_HI)
        paddr_d[8] = bank_q[BANK_BIT];
      bitill_d = bit_op_in && !(data_addr_in >= F_RAM_LO && data_addr_in <= F_BIT_HI)
                 && data_addr_in >= F_RAM_LO;
      if (data_we_in)
      begin
        unique case (data_addr_in)
          F_BANK_ADDR: bank_d = data_wdata_in;
          F_FSR_ADDR:  fsr_d  = data_wdata_in;
          F_RSR_ADDR:  rsr_d  = data_wdata_in;
          default:     ;
        endcase
      end
    end
    if (any_reset)
    begin
      run_d    = 1'b1;
      irq_en_d = '0;
      fsr_d    = FSR_RESET;
      rsr_d    = RSR_RESET;
      clk_d    = CLK_RESET;
      bank_d   = 8'h00;
      rdata_d  = 32'h0000_0000;
      wait_d   = 1'b1;
      aux_d    = 1'b0;
      bitill_d = 1'b0;
      if (!rst_n_in || por_in)
        cfg_d = cfg_word_in & ~CFG_RESERVED_MASK;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    run_q    <= run_d;
    irq_en_q <= irq_en_d;
    cfg_q    <= cfg_d;
    fsr_q    <= fsr_d;
    rsr_q    <= rsr_d;
    clk_q    <= clk_d;
    bank_q   <= bank_d;
    rdata_q  <= rdata_d;
    wait_q   <= wait_d;
    paddr_q  <= paddr_d;
    aux_q    <= aux_d;
    bitill_q <= bitill_d;
    rst_q    <= any_reset;
  end

  assign phase_one_out           = (phase_q == MCUCC_PH_ONE);
  assign phase_two_out           = (phase_q == MCUCC_PH_TWO);
  assign pc_out                  = pc_q;
  assign ir_latch_out            = irlat_q;
  assign crystal_osc_enable_out  = clk_q[CLK_XTAL_BIT];
  assign internal_osc_enable_out = clk_q[CLK_RC_BIT];
  assign cpu_clk_sel_pll_out     = clk_q[CLK_XTAL_BIT];
  assign pll_internal_filter_out = cfg_q[CFG_FILTER_BIT];
  assign rc_freq_trim_out        = cfg_q[CFG_TRIM_HI:CFG_TRIM_LO];
  assign flash_read_block_out    = cfg_q[CFG_PROTECT_BIT];
  assign core_reset_out          = rst_q;
  assign data_phys_addr_out      = paddr_q;
  assign aux_access_out          = aux_q;
  assign bit_op_illegal_out      = bitill_q;
  assign avs_readdata_out        = rdata_q;
  assign avs_waitrequest_out     = wait_q;

  // Checks
  phase_alt_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    phase_q == MCUCC_PH_ONE |=> phase_q == MCUCC_PH_TWO) else $error("phase stuck");
  reset_pc_a: assert property (@(posedge core_clk_in)
    any_reset |=> pc_q == RESET_VECTOR) else $error("pc not zero after reset");
  branch_two_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    br_q && phase_q == MCUCC_PH_ONE |=> !br_q) else $error("branch length");
  irq_vec_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    run_q && phase_q == MCUCC_PH_ONE && !br_q && irq_hit && !in_isr_q
    |=> in_isr_q && pc_q == $past(irq_vec)) else $error("bad vector");
  nest_one_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    in_isr_q |=> in_isr_q) else $error("nesting left");
  mask_gate_a: assert property (@(posedge core_clk_in)
    irq_hit |-> |(irq_req_in & irq_en_q)) else $error("masked source vectored");
  protect_out_a: assert property (@(posedge core_clk_in)
    flash_read_block_out == cfg_q[CFG_PROTECT_BIT]) else $error("protect mismatch");
  bank_reset_a: assert property (@(posedge core_clk_in)
    any_reset |=> bank_q == 8'h00 && fsr_q == FSR_RESET) else $error("bank reset");
  cfg_lock_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    cfg_q[CFG_PROTECT_BIT] && !flash_blank_in |=> $stable(cfg_q)) else $error("cfg overwritten");
  primary_indirect_port_a: assert property (@(posedge core_clk_in) disable iff (any_reset)
    !aux_sel_in && data_addr_in == F_PRIMARY_INDIRECT_PORT_ADDR |=> paddr_q[7:0] == $past(fsr_q))
    else $error("indirect wrong");
  cv_irq: cover property (@(posedge core_clk_in) irq_hit && !in_isr_q && run_q);
  cv_branch: cover property (@(posedge core_clk_in) br_q);
  cv_aux: cover property (@(posedge core_clk_in) aux_q);

endmodule // mcucc_core
`default_nettype wire

// ==== shared/mcucc_pkg.sv ====
package mcucc_pkg;

  localparam int PC_W   = 13;
  localparam int CFG_W  = 14;
  localparam int NIRQ   = 17;
  localparam int DATA_W = 8;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_BASE     = 13'h0001;
  localparam logic [PC_W-1:0] PC_LAST      = 13'h1FFF;
  localparam int IRQ_RESERVED_IDX          = 15;

  localparam int CFG_PROTECT_BIT = 13;
  localparam int CFG_FILTER_BIT  = 8;
  localparam int CFG_TRIM_HI     = 4;
  localparam int CFG_TRIM_LO     = 0;
  localparam logic [CFG_W-1:0] CFG_RESERVED_MASK = 14'h1EE0;
  localparam int CFG_WORDS = 32;

  localparam int CLK_XTAL_BIT = 4;
  localparam int CLK_RC_BIT   = 3;
  localparam int BANK_BIT     = 5;

  localparam logic [7:0] F_PRIMARY_INDIRECT_PORT_ADDR  = 8'h00;
  localparam logic [7:0] F_BANK_ADDR  = 8'h03;
  localparam logic [7:0] F_FSR_ADDR   = 8'h04;
  localparam logic [7:0] F_RSR_ADDR   = 8'h05;
  localparam logic [7:0] F_RAM_LO     = 8'h20;
  localparam logic [7:0] F_BIT_HI     = 8'h3F;
  localparam logic [7:0] F_BANKED_LO  = 8'h40;
  localparam logic [7:0] F_RAM_HI     = 8'h7F;
  localparam logic [7:0] R_AUX_INDIRECT_PORT_ADDR  = 8'h00;
  localparam logic [7:0] R_CLK_ADDR   = 8'h07;
  localparam logic [7:0] R_RAM0_LO    = 8'h40;
  localparam logic [7:0] R_FIFO_LO    = 8'hC0;
  localparam logic [7:0] R_FIFO_HI    = 8'hE7;

  localparam logic [7:0] FSR_RESET  = 8'h00;
  localparam logic [7:0] RSR_RESET  = 8'h00;
  localparam logic [7:0] CLK_RESET  = 8'h10;

  // Avalon register byte addresses
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h4;
  localparam logic [3:0] A_CFG    = 4'h8;
  localparam logic [3:0] A_IRQEN  = 4'hC;

  localparam logic [1:0] CTRL_RUN_BIT  = 2'h0;
  localparam logic [1:0] CTRL_BR_BIT   = 2'h1;

  typedef enum logic [1:0] {
    MCUCC_PH_ONE = 2'b00,
    MCUCC_PH_TWO = 2'b01
  } mcucc_phase_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } mcucc_avreq_t;

endpackage
